/* File: slow_clock_pkg.sv */
// constants, field layout and source enumeration for the slow clock control block
// assumes one 250 MHz system clock; oscillator outputs arrive asynchronously
package slow_clock_pkg;
    localparam int          ADDR_W          = 28;
    localparam logic [27:0] SLOW_CTRL_ADDR  = 28'hFFFFD50;
    localparam logic [27:0] DIV_CTRL_ADDR   = 28'hFFFFD54;
    localparam logic [27:0] STATUS_ADDR     = 28'hFFFFD58;
    // slow_clock_control fields
    localparam int          RC_EN_BIT       = 0;
    localparam int          XTAL_EN_BIT     = 1;
    localparam int          BYPASS_BIT      = 2;
    localparam int          SELECT_BIT      = 3;
    localparam logic        RC_EN_RESET     = 1'h1;
    localparam logic        XTAL_EN_RESET   = 1'h0;
    localparam logic        BYPASS_RESET    = 1'h0;
    localparam logic        SELECT_RESET    = 1'h0;
    // divider control fields
    localparam int          MASTER_DIVIDER_FIELD_LSB        = 0;
    localparam int          PRESCALE_BIT    = 4;
    localparam int          USB_DIV_LSB     = 8;
    localparam logic [1:0]  MASTER_DIVIDER_FIELD_RESET      = 2'h0;
    localparam logic        PRESCALE_RESET  = 1'h0;
    localparam logic [3:0]  USB_DIV_RESET   = 4'h9;
    // status fields
    localparam int          BUSY_BIT        = 0;
    localparam int          ACTIVE_LSB      = 1;
    localparam int          MEM_AVAIL_BIT   = 3;
    // master divider codes
    localparam logic [1:0]  MASTER_DIVIDER_FIELD_BY1        = 2'h0;
    localparam logic [1:0]  MASTER_DIVIDER_FIELD_BY2        = 2'h1;
    localparam logic [1:0]  MASTER_DIVIDER_FIELD_BY4        = 2'h2;
    localparam logic [1:0]  MASTER_DIVIDER_FIELD_BY3        = 2'h3;
    localparam int          SWITCH_SLOW_CYCLES = 5;
    localparam int          SYNC_STAGES     = 3;

    typedef enum logic [1:0] {SRC_RC, SRC_XTAL, SRC_PIN} slow_source_type;

    // divide ratio minus one for each master divider code
    function automatic logic [3:0] master_divider_field_ratio(input logic [1:0] code);
        logic [3:0] r;
        r = 4'h0;
        unique case (code)
            MASTER_DIVIDER_FIELD_BY1: r = 4'h0;
            MASTER_DIVIDER_FIELD_BY2: r = 4'h1;
            MASTER_DIVIDER_FIELD_BY4: r = 4'h3;
            MASTER_DIVIDER_FIELD_BY3: r = 4'h2;
        endcase
        return r;
    endfunction
endpackage

/* File: tick_divider.sv */
// counts input ticks and pulses once every ratio_i+1 of them, plus a mid-period pulse when ratio_i is not zero
// assumes tick_i is a one-cycle enable on clk_sys_i
`timescale 1ns/1ns
module tick_divider (
    input  wire logic       clk_sys_i,
    input  wire logic       reset_i,
    input  wire logic       ce_i,
    input  wire logic       tick_i,
    input  wire logic [3:0] ratio_i,
    output logic            tick_o,
    output logic            mid_o
);
    logic [3:0] count;
    logic [3:0] seen;
    logic       ratio_stable;

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            count  <= 4'h0;
            tick_o <= 1'h0;
            mid_o  <= 1'h0;
        end else if (ce_i) begin
            tick_o <= tick_i && (count >= ratio_i);
            mid_o  <= tick_i && (count == (ratio_i >> 1)) && (ratio_i != 4'h0);
            if (tick_i) begin
                // a ratio lowered mid-period wraps at once instead of running to 15
                count <= (count >= ratio_i) ? 4'h0 : count + 4'h1;
            end
        end
    end

    // helper: input ticks since the last output pulse, with no ratio change seen
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            seen         <= 4'h0;
            ratio_stable <= 1'h0;
        end else if (ce_i) begin
            if (tick_o) begin
                seen         <= {3'h0, tick_i};
                ratio_stable <= 1'h1;
            end else begin
                seen <= seen + {3'h0, tick_i};
            end
            if (ratio_i != $past(ratio_i)) ratio_stable <= 1'h0;
        end
    end

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    property p_period;
        // the pulse was launched under the ratio of the cycle before
        tick_o && ratio_stable && $past(ce_i) |-> seen == $past(ratio_i) + 4'h1;
    endproperty
    a_period: assert property (p_period) else $error("divider period wrong");
endmodule

/* File: slow_clock_mux.sv */
// glitch-free switch between three filtered slow clock levels
// assumes levels_i are already synchronised to clk_sys_i
`timescale 1ns/1ns
module slow_clock_mux (
    input  wire logic                          clk_sys_i,
    input  wire logic                          reset_i,
    input  wire logic                          ce_i,
    input  wire logic [2:0]                    levels_i,
    input  wire slow_clock_pkg::slow_source_type request_i,
    output logic                               slow_clock_o,
    output slow_clock_pkg::slow_source_type    active_o,
    output logic                               busy_o
);
    typedef enum logic [1:0] {FOLLOW, DRAIN, WAIT_NEW} mux_state_type;
    mux_state_type state;
    logic [3:0]    new_edges;
    logic          new_prev;
    logic          prev_level;

    // old source runs down to low, then output idles low until the new source falls;
    // a switch onto a stopped oscillator waits until it runs
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            state      <= FOLLOW;
            active_o   <= slow_clock_pkg::SRC_RC;
            prev_level <= 1'h0;
        end else if (ce_i) begin
            prev_level <= levels_i[active_o];
            unique case (state)
                FOLLOW: begin
                    // old source already low: its low phase simply stretches
                    if (request_i != active_o) begin
                        if (levels_i[active_o]) begin
                            state <= DRAIN;
                        end else begin
                            active_o <= request_i;
                            state    <= WAIT_NEW;
                        end
                    end
                end
                DRAIN: begin
                    if (!levels_i[active_o]) begin
                        active_o <= request_i;
                        state    <= WAIT_NEW;
                    end
                end
                WAIT_NEW: begin
                    // a fall, not a low level, so the first new low phase is whole
                    if (!levels_i[active_o] && prev_level) state <= FOLLOW;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            slow_clock_o <= 1'h0;
        end else if (ce_i) begin
            slow_clock_o <= (state != WAIT_NEW) && levels_i[active_o];
        end
    end

    assign busy_o = (state != FOLLOW) || (request_i != active_o);

    // helper: rising edges of the requested source during one switch
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            new_edges <= 4'h0;
            new_prev  <= 1'h0;
        end else if (ce_i) begin
            new_prev <= levels_i[request_i];
            if (!busy_o) new_edges <= 4'h0;
            else if (levels_i[request_i] && !new_prev && new_edges != 4'hF)
                new_edges <= new_edges + 4'h1;
        end
    end

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    property p_no_rise_switching;
        $rose(slow_clock_o) |-> $past(state) != WAIT_NEW && $past(state) != DRAIN;
    endproperty
    a_no_rise_switching: assert property (p_no_rise_switching)
        else $error("slow clock rose while switching");

    property p_resync_bound;
        busy_o |-> new_edges <= 4'(slow_clock_pkg::SWITCH_SLOW_CYCLES);
    endproperty
    a_resync_bound: assert property (p_resync_bound)
        else $error("source switch took over five slow cycles");
endmodule

/* File: slow_clock_source_control.sv */
// slow clock source control with master, memory and usb clock enables
// assumes reset_i is the backup power-on reset and oscillator outputs are asynchronous
// Summary of operation
// - slow clock comes from the crystal or the RC oscillator per select bit.
// - with bypass set and the select bit 1, the crystal input pin level is used as the clock.
// - each oscillator runs only while its enable bit is 1.
// - the four control bits live in one backup-domain control register.
// - after backup reset: RC on, crystal off, RC selected.
// - a select change completes resynchronisation within five slow clock cycles.
// - master clock is processor clock divided by 1, 2, 3 or 4.
// - memory clock runs at twice master; absent when master equals processor.
// - usb divider divides by field value plus one.
// - master divider code 11 gives one third of processor clock.
// - prescaler 2 with code 01 gives master at half processor clock.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns
module slow_clock_source_control (
    input  wire logic        clk_sys_i,
    input  wire logic        reset_i,
    input  wire logic        ce_i,
    input  wire logic [27:0] reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_write_i,
    input  wire logic        reg_read_i,
    output logic      [31:0] reg_rdata_o,
    input  wire logic        rc_osc_clk_i,
    input  wire logic        crystal_osc_clk_i,
    input  wire logic        crystal_input_pin_i,
    output logic             rc_osc_enable_o,
    output logic             crystal_osc_enable_o,
    output logic             crystal_bypass_bit_o,
    output logic             slow_clock_o,
    output logic             slow_switch_busy_o,
    output logic             processor_tick_o,
    output logic             master_tick_o,
    output logic             memory_tick_o,
    output logic             usb_fs_tick_o
);
    logic                            slow_source_select;
    logic [1:0]                      master_divider_field;
    logic                            prescale_by2;
    logic [3:0]                      usb_fs_divider_field;
    logic [2:0]                      raw_level;
    wire logic [2:0]                 filt_level;
    slow_clock_pkg::slow_source_type next_request;
    slow_clock_pkg::slow_source_type active_source;
    logic                            master_mid;
    logic                            memory_available;
    logic                            ctrl_hit;
    logic                            div_hit;
    logic                            status_hit;

    assign ctrl_hit   = reg_addr_i == slow_clock_pkg::SLOW_CTRL_ADDR;
    assign div_hit    = reg_addr_i == slow_clock_pkg::DIV_CTRL_ADDR;
    assign status_hit = reg_addr_i == slow_clock_pkg::STATUS_ADDR;

    // slow_clock_control: only backup reset clears it, so it survives core resets
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            rc_osc_enable_o      <= slow_clock_pkg::RC_EN_RESET;
            crystal_osc_enable_o <= slow_clock_pkg::XTAL_EN_RESET;
            crystal_bypass_bit_o <= slow_clock_pkg::BYPASS_RESET;
            slow_source_select   <= slow_clock_pkg::SELECT_RESET;
        end else if (ce_i && reg_write_i && ctrl_hit) begin
            rc_osc_enable_o      <= reg_wdata_i[slow_clock_pkg::RC_EN_BIT];
            crystal_osc_enable_o <= reg_wdata_i[slow_clock_pkg::XTAL_EN_BIT];
            crystal_bypass_bit_o <= reg_wdata_i[slow_clock_pkg::BYPASS_BIT];
            slow_source_select   <= reg_wdata_i[slow_clock_pkg::SELECT_BIT];
        end
    end

    // divider control
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            master_divider_field <= slow_clock_pkg::MASTER_DIVIDER_FIELD_RESET;
            prescale_by2         <= slow_clock_pkg::PRESCALE_RESET;
            usb_fs_divider_field <= slow_clock_pkg::USB_DIV_RESET;
        end else if (ce_i && reg_write_i && div_hit) begin
            master_divider_field <= reg_wdata_i[slow_clock_pkg::MASTER_DIVIDER_FIELD_LSB +: 2];
            prescale_by2         <= reg_wdata_i[slow_clock_pkg::PRESCALE_BIT];
            usb_fs_divider_field <= reg_wdata_i[slow_clock_pkg::USB_DIV_LSB +: 4];
        end
    end

    // read data stand only in the cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            reg_rdata_o <= 32'h0;
        end else if (ce_i) begin
            reg_rdata_o <= 32'h0;
            if (reg_read_i && ctrl_hit) begin
                reg_rdata_o[slow_clock_pkg::RC_EN_BIT]   <= rc_osc_enable_o;
                reg_rdata_o[slow_clock_pkg::XTAL_EN_BIT] <= crystal_osc_enable_o;
                reg_rdata_o[slow_clock_pkg::BYPASS_BIT]  <= crystal_bypass_bit_o;
                reg_rdata_o[slow_clock_pkg::SELECT_BIT]  <= slow_source_select;
            end else if (reg_read_i && div_hit) begin
                reg_rdata_o[slow_clock_pkg::MASTER_DIVIDER_FIELD_LSB +: 2]    <= master_divider_field;
                reg_rdata_o[slow_clock_pkg::PRESCALE_BIT]     <= prescale_by2;
                reg_rdata_o[slow_clock_pkg::USB_DIV_LSB +: 4] <= usb_fs_divider_field;
            end else if (reg_read_i && status_hit) begin
                reg_rdata_o[slow_clock_pkg::BUSY_BIT]       <= slow_switch_busy_o;
                reg_rdata_o[slow_clock_pkg::ACTIVE_LSB +: 2] <= active_source;
                reg_rdata_o[slow_clock_pkg::MEM_AVAIL_BIT]  <= memory_available;
            end
        end
    end

    // a disabled oscillator reads as a steady low, so a switch away from it never stalls
    assign raw_level[0] = rc_osc_clk_i & rc_osc_enable_o;
    assign raw_level[1] = crystal_osc_clk_i & crystal_osc_enable_o;
    assign raw_level[2] = crystal_input_pin_i;

    // three-stage synchronisers; a level change counts once stages two and three agree
    for (genvar i = 0; i < slow_clock_pkg::SYNC_STAGES; i++) begin : g_sync
        logic stage1;
        logic stage2;
        logic stage3;
        logic filtered;
        always_ff @(posedge clk_sys_i or posedge reset_i) begin
            if (reset_i) begin
                stage1   <= 1'h0;
                stage2   <= 1'h0;
                stage3   <= 1'h0;
                filtered <= 1'h0;
            end else if (ce_i) begin
                stage1 <= raw_level[i];
                stage2 <= stage1;
                stage3 <= stage2;
                if (stage2 == stage3) filtered <= stage3;
            end
        end
        assign filt_level[i] = filtered;
    end

    // bypass is part of the source choice, so toggling it while the select bit is 1 also goes through the switch
    always_comb begin
        next_request = slow_clock_pkg::SRC_RC;
        if (slow_source_select)
            next_request = crystal_bypass_bit_o ? slow_clock_pkg::SRC_PIN
                                                : slow_clock_pkg::SRC_XTAL;
    end

    slow_clock_mux u_mux (
        .clk_sys_i    (clk_sys_i),
        .reset_i      (reset_i),
        .ce_i         (ce_i),
        .levels_i     (filt_level),
        .request_i    (next_request),
        .slow_clock_o (slow_clock_o),
        .active_o     (active_source),
        .busy_o       (slow_switch_busy_o)
    );

    // processor clock: system input clock through the prescaler
    tick_divider u_prescale (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .ce_i      (ce_i),
        .tick_i    (1'h1),
        .ratio_i   ({3'h0, prescale_by2}),
        .tick_o    (processor_tick_o),
        .mid_o     ()
    );

    tick_divider u_master (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .ce_i      (ce_i),
        .tick_i    (processor_tick_o),
        .ratio_i   (slow_clock_pkg::master_divider_field_ratio(master_divider_field)),
        .tick_o    (master_tick_o),
        .mid_o     (master_mid)
    );

    // divide by three gives uneven memory ticks: 1.5 processor ticks cannot be split
    assign memory_available = master_divider_field != slow_clock_pkg::MASTER_DIVIDER_FIELD_BY1;
    assign memory_tick_o    = memory_available && (master_tick_o || master_mid);

    // usb full-speed clock from the system input clock
    tick_divider u_usb (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .ce_i      (ce_i),
        .tick_i    (1'h1),
        .ratio_i   (usb_fs_divider_field),
        .tick_o    (usb_fs_tick_o),
        .mid_o     ()
    );

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    property p_reset_state;
        $fell(reset_i) |-> rc_osc_enable_o && !crystal_osc_enable_o && !slow_source_select;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("wrong slow clock setup after reset");

    property p_enable_write;
        ce_i && reg_write_i && ctrl_hit |=>
            rc_osc_enable_o == $past(reg_wdata_i[slow_clock_pkg::RC_EN_BIT]) &&
            crystal_osc_enable_o == $past(reg_wdata_i[slow_clock_pkg::XTAL_EN_BIT]);
    endproperty
    a_enable_write: assert property (p_enable_write)
        else $error("oscillator enable did not follow write");

    property p_readback;
        ce_i && reg_read_i && ctrl_hit |=>
            reg_rdata_o == {28'h0, $past(slow_source_select), $past(crystal_bypass_bit_o),
                            $past(crystal_osc_enable_o), $past(rc_osc_enable_o)};
    endproperty
    a_readback: assert property (p_readback)
        else $error("control register readback wrong");

    property p_rc_follow;
        ce_i && $past(ce_i) && !slow_switch_busy_o && $past(!slow_switch_busy_o) &&
            !slow_source_select |-> slow_clock_o == $past(filt_level[0]);
    endproperty
    a_rc_follow: assert property (p_rc_follow)
        else $error("slow clock not following rc source");

    property p_bypass_follow;
        ce_i && $past(ce_i) && !slow_switch_busy_o && $past(!slow_switch_busy_o) &&
            slow_source_select && crystal_bypass_bit_o |-> slow_clock_o == $past(filt_level[2]);
    endproperty
    a_bypass_follow: assert property (p_bypass_follow)
        else $error("slow clock not following crystal pin in bypass");

    property p_no_memory_div1;
        master_divider_field == slow_clock_pkg::MASTER_DIVIDER_FIELD_BY1 && master_tick_o |-> !memory_tick_o;
    endproperty
    a_no_memory_div1: assert property (p_no_memory_div1)
        else $error("memory clock present with master equal to processor");

    c_to_crystal: cover property ($fell(slow_switch_busy_o) && active_source == slow_clock_pkg::SRC_XTAL);
    c_to_pin: cover property ($fell(slow_switch_busy_o) && active_source == slow_clock_pkg::SRC_PIN);
    c_back_to_rc: cover property ($fell(slow_switch_busy_o) && active_source == slow_clock_pkg::SRC_RC);
    c_third: cover property (master_tick_o && master_divider_field == slow_clock_pkg::MASTER_DIVIDER_FIELD_BY3);
endmodule

/* File: slow_clock_source_control_test.sv */
// self-checking bench for the slow clock source control block
// assumes the bench models both oscillators and the external pin clock itself
`timescale 1ns/1ns
module slow_clock_source_control_test;
    typedef struct {
        logic [27:0] addr;
        logic [31:0] wdata;
        logic [31:0] exp_rd;
        logic [2:0]  outs;
        int          pp;
        int          mp;
        int          up;
        int          mem;
    } row_type;
    localparam logic [27:0] CTRL = slow_clock_pkg::SLOW_CTRL_ADDR;
    localparam logic [27:0] DIVR = slow_clock_pkg::DIV_CTRL_ADDR;
    localparam logic [27:0] STAT = slow_clock_pkg::STATUS_ADDR;
    logic        clk_sys_i           = 1'b0;
    logic        reset_i             = 1'b1;
    logic        ce_i                = 1'b1;
    logic [27:0] reg_addr_i          = 28'h0000000;
    logic [31:0] reg_wdata_i         = 32'h00000000;
    logic        reg_write_i         = 1'b0;
    logic        reg_read_i          = 1'b0;
    logic        rc_osc_clk_i        = 1'b0;
    logic        crystal_osc_clk_i   = 1'b0;
    logic        crystal_input_pin_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic        rc_osc_enable_o, crystal_osc_enable_o, crystal_bypass_bit_o;
    logic        slow_clock_o, slow_switch_busy_o;
    logic        processor_tick_o, master_tick_o, memory_tick_o, usb_fs_tick_o;
    int          fails = 0;
    int          n_checks = 0;
    int          run = 0;
    int          min_phase = 99;
    logic        seen = 1'b0;
    logic        last_slow = 1'b0;
    logic [31:0] d;
    int          p;
    // dividers run off the 250 MHz system clock, far above the 2 MHz floor
    // rc and crystal rows stay rc-enabled so no phase is cut by software
    row_type rows [10] = '{
        '{CTRL, 32'h00000003, 32'h00000003, 3'h3, 0, 0, 0, 0},
        '{CTRL, 32'h00000007, 32'h00000007, 3'h7, 0, 0, 0, 0},
        '{CTRL, 32'hFFFFFFF5, 32'h00000005, 3'h5, 0, 0, 0, 0},
        '{CTRL, 32'h00000001, 32'h00000001, 3'h1, 0, 0, 0, 0},
        '{DIVR, 32'h00000900, 32'h00000900, 3'h0, 1, 1, 10, 0},
        '{DIVR, 32'h00000911, 32'h00000911, 3'h0, 2, 4, 10, 2},
        '{DIVR, 32'h00000702, 32'h00000702, 3'h0, 1, 4, 8, 2},
        '{DIVR, 32'h00000703, 32'h00000703, 3'h0, 1, 3, 8, 2},
        '{STAT, 32'h0000000F, 32'h00000008, 3'h0, 0, 0, 0, 0},
        '{28'hFFFFD5C, 32'h0000000F, 32'h00000000, 3'h0, 0, 0, 0, 0}
    };

    slow_clock_source_control uut (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(ce_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
        .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .rc_osc_clk_i(rc_osc_clk_i),
        .crystal_osc_clk_i(crystal_osc_clk_i), .crystal_input_pin_i(crystal_input_pin_i),
        .rc_osc_enable_o(rc_osc_enable_o), .crystal_osc_enable_o(crystal_osc_enable_o),
        .crystal_bypass_bit_o(crystal_bypass_bit_o), .slow_clock_o(slow_clock_o),
        .slow_switch_busy_o(slow_switch_busy_o), .processor_tick_o(processor_tick_o),
        .master_tick_o(master_tick_o), .memory_tick_o(memory_tick_o),
        .usb_fs_tick_o(usb_fs_tick_o));

    initial forever #2 clk_sys_i = ~clk_sys_i;
    // a disabled oscillator stops low, as the real cell would
    initial forever #20 rc_osc_clk_i = (rc_osc_enable_o === 1'b1) ? ~rc_osc_clk_i : 1'b0;
    initial forever #28 crystal_osc_clk_i = (crystal_osc_enable_o === 1'b1) ?
                                            ~crystal_osc_clk_i : 1'b0;
    initial forever #30 crystal_input_pin_i = ~crystal_input_pin_i;

    // shortest high or low phase seen on the slow clock since reset
    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            seen <= 1'b0;
            run <= 0;
        end else if (slow_clock_o !== last_slow) begin
            if (seen && run < min_phase) min_phase <= run;
            seen <= 1'b1;
            run <= 1;
        end else run <= run + 1;
        last_slow <= slow_clock_o;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [27:0] a, input logic [31:0] v);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_write_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_write_i <= 1'b0;
    endtask

    task automatic rd(input logic [27:0] a, output logic [31:0] v);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_read_i <= 1'b0;
        // data stand only in the cycle after the strobe
        #1 v = reg_rdata_o;
    endtask

    function automatic logic tk(input int w);
        case (w)
            0: return processor_tick_o;
            1: return master_tick_o;
            2: return usb_fs_tick_o;
            default: return memory_tick_o;
        endcase
    endfunction

    // cycles from one pulse of the chosen tick to the next
    task automatic period(input int w, output int n);
        int g;
        #1 g = 0;
        n = 0;
        while (tk(w) !== 1'b1 && g < 200) begin
            @(posedge clk_sys_i);
            #1 g++;
        end
        do begin
            @(posedge clk_sys_i);
            #1 n++;
        end while (tk(w) !== 1'b1 && n < 200);
    endtask

    task automatic count(input int w, input int cycles, output int c);
        c = 0;
        repeat (cycles) begin
            @(posedge clk_sys_i);
            #1 if (tk(w) === 1'b1) c++;
        end
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        #1 chk(32'(slow_switch_busy_o), 32'h1);
        while (slow_switch_busy_o !== 1'b0 && n < 70) begin
            @(posedge clk_sys_i);
            #1 n++;
        end
        chk(32'(slow_switch_busy_o), 32'h0);
    endtask

    // the selected slow clock keeps toggling
    task automatic toggles();
        int c;
        logic l;
        c = 0;
        l = slow_clock_o;
        repeat (60) begin
            @(posedge clk_sys_i);
            #1 if (slow_clock_o !== l) c++;
            l = slow_clock_o;
        end
        chk(32'(c > 4), 32'h1);
    endtask

    task automatic switch_to(input logic [31:0] v, input logic [31:0] act);
        wr(CTRL, v);
        wait_idle();
        rd(STAT, d);
        chk(d & 32'h00000007, act);
        toggles();
    endtask

    initial begin
        #100000 fails++;
        end_sim();
    end

    initial begin
        repeat (5) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        rd(CTRL, d);
        chk(d, 32'h00000001);
        for (int i = 0; i < 10; i++) begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, d);
            chk(d & 32'h00000F1F, rows[i].exp_rd);
            if (rows[i].addr == CTRL)
                chk({29'h0, crystal_bypass_bit_o, crystal_osc_enable_o, rc_osc_enable_o},
                    {29'h0, rows[i].outs});
            if (rows[i].pp != 0) begin
                repeat (20) @(posedge clk_sys_i);
                period(0, p);
                chk(p, rows[i].pp);
                period(2, p);
                chk(p, rows[i].up);
                period(1, p);
                chk(p, rows[i].mp);
                count(3, 6 * rows[i].mp, p);
                chk(p, 6 * rows[i].mem);
            end
        end
        $display("test done: register and divider table");
        wr(CTRL, 32'h00000003);
        repeat (40) @(posedge clk_sys_i);
        // master ticks come from the system clock, never from the slow clock
        count(1, 8, p);
        chk(32'(p > 0), 32'h1);
        switch_to(32'h0000000B, 32'h00000002);
        wr(CTRL, 32'h0000000A);
        #1 chk(32'(rc_osc_enable_o), 32'h0);
        toggles();
        switch_to(32'h0000000E, 32'h00000004);
        wr(CTRL, 32'h0000000C);
        toggles();
        wr(CTRL, 32'h0000000D);
        repeat (40) @(posedge clk_sys_i);
        switch_to(32'h00000005, 32'h00000000);
        wr(CTRL, 32'h00000001);
        chk(32'(min_phase >= 3), 32'h1);
        $display("test done: slow clock switching");
        @(posedge clk_sys_i);
        ce_i <= 1'b0;
        wr(CTRL, 32'h00000003);
        @(posedge clk_sys_i);
        ce_i <= 1'b1;
        rd(CTRL, d);
        chk(d, 32'h00000001);
        $display("test done: clock enable low");
        wr(CTRL, 32'h00000003);
        @(posedge clk_sys_i);
        reset_i <= 1'b1;
        repeat (5) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        rd(CTRL, d);
        chk(d, 32'h00000001);
        chk({29'h0, crystal_bypass_bit_o, crystal_osc_enable_o, rc_osc_enable_o},
            32'h00000001);
        rd(DIVR, d);
        chk(d & 32'h00000F1F, 32'h00000900);
        $display("test done: reset in mid run");
        end_sim();
    end
endmodule
